// ==== volume_ramp_map.svh ====
// Register map, field positions, reset values and timing constants of the volume ramp block
// Functional notes
// - Normal ramp-down updates every 1, 2 or 4 samples for rate codes 00, 01, 10; 11 jumps to the lower target or mute level at once.
// - Normal ramp-down lowers the level by 4, 2, 1 or 0.5 dB per update for codes 00 to 11.
// - Normal ramp-up updates every 1, 2 or 4 samples for codes 00, 01, 10; 11 restores at once.
// - Normal ramp-up raises the level by 4, 2, 1 or 0.5 dB per update for codes 00 to 11.
// - On a clock error or power loss the emergency rate field picks 1, 2, 4 samples or instant mute.
// - Emergency ramp-down lowers the level by 4, 2, 1 or 0.5 dB per update for codes 00 to 11.
// - Grouping bit 0 mutes each channel alone; 1 mutes only when both qualify at the same time.
// - Right channel silence mute acts only while its enable bit is set.
// - Left channel silence mute acts only while its enable bit is set.
// - Left channel qualifies after a zero run of 11.5 ms up to 5330 ms chosen by its 3-bit code.
// - Right channel qualifies after a zero run chosen by its 3-bit code with the same table.
// - Silence times are defined at 96 kHz and are counted in samples, so they scale with rate.
// - Level codes run from +24 dB at 0x00 in 0.5 dB steps, 0x30 is 0 dB and 0xff is mute.
`ifndef VOLUME_RAMP_MAP_SVH
`define VOLUME_RAMP_MAP_SVH

// ******************************
// Register offsets and resets
// ******************************
`define NORMAL_RAMP_OFS      8'h4e
`define EMERGENCY_RAMP_OFS   8'h4f
`define SILENCE_CTRL_OFS     8'h50
`define SILENCE_DELAY_OFS    8'h51
`define NORMAL_RAMP_RST      8'h33
`define EMERGENCY_RAMP_RST   8'h30
`define SILENCE_CTRL_RST     8'h07
`define SILENCE_DELAY_RST    8'h00

// ******************************
// Field positions (low bit)
// ******************************
`define DOWN_RATE_POS        6
`define DOWN_STEP_POS        4
`define UP_RATE_POS          2
`define UP_STEP_POS          0
`define GROUPING_POS         2
`define ENABLE_RIGHT_POS     1
`define ENABLE_LEFT_POS      0
`define DELAY_LEFT_POS       4
`define DELAY_RIGHT_POS      0

// ******************************
// Level codes and timing
// ******************************
`define LEVEL_MUTE           8'hff
`define LEVEL_0DB            8'h30
`define RATE_INSTANT         2'b11
`define SILENCE_FS_KHZ       96
`define SILENCE_T0_US        11500
`define SILENCE_T1_US        53000
`define SILENCE_T2_US        106500
`define SILENCE_T3_US        266500
`define SILENCE_T4_US        535000
`define SILENCE_T5_US        1065000
`define SILENCE_T6_US        2665000
`define SILENCE_T7_US        5330000
`define SILENCE_CNT(us)      (((us) * `SILENCE_FS_KHZ) / 1000)

`endif

// ==== volume_ramp_pkg.sv ====
// Types shared by the volume ramp block and its output buffer
package volume_ramp_pkg;
   localparam int SAMPLE_W = 24;
   localparam int RUN_W    = 19;

   typedef logic [7:0]          level_t;
   typedef logic [SAMPLE_W-1:0] sample_t;
   typedef logic [RUN_W-1:0]    run_t;

   typedef struct packed {
      sample_t left;
      sample_t right;
      level_t  level_left;
      level_t  level_right;
   } frame_t;

   typedef enum logic [1:0] {
      RAMP_IDLE,
      RAMP_DOWN,
      RAMP_UP,
      RAMP_EMERGENCY
   } ramp_state_t;
endpackage

// ==== frame_stream_if.sv ====
// Valid/ready carrier for processed frames between the ramp core and its buffer
`timescale 1ns/1ps
interface frame_stream_if;
   import volume_ramp_pkg::*;
   logic   valid;
   logic   ready;
   frame_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== frame_buffer.sv ====
// Two-entry frame buffer with registered valid, data and ready
`timescale 1ns/1ps
module frame_buffer
   import volume_ramp_pkg::*;
(
   input  wire logic     sys_clk_i,
   input  wire logic     srst_i,
   frame_stream_if.snk   in_s,
   output logic          out_valid_o,
   input  wire logic     out_ready_i,
   output frame_t        out_data_o
);
   frame_t head_q, head_d, tail_q, tail_d;
   logic   head_v_q, head_v_d, tail_v_q, tail_v_d;
   logic   pop, push;

   // Ready is a flop: the upstream sees room only while the tail slot is empty
   assign in_s.ready  = ~tail_v_q;
   assign out_valid_o = head_v_q;
   assign out_data_o  = head_q;

   always_comb begin
      pop      = head_v_q & out_ready_i;
      push     = in_s.valid & ~tail_v_q;
      head_d   = head_q;
      tail_d   = tail_q;
      head_v_d = head_v_q;
      tail_v_d = tail_v_q;
      if (pop) begin
         head_d   = tail_q;
         head_v_d = tail_v_q;
         tail_v_d = 1'b0;
      end
      if (push) begin
         if (!head_v_d) begin
            head_d   = in_s.data;
            head_v_d = 1'b1;
         end else begin
            tail_d   = in_s.data;
            tail_v_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         head_v_q <= 1'b0;
         tail_v_q <= 1'b0;
         head_q   <= '0;
         tail_q   <= '0;
      end else begin
         head_v_q <= head_v_d;
         tail_v_q <= tail_v_d;
         head_q   <= head_d;
         tail_q   <= tail_d;
      end
   end
endmodule

// ==== volume_ramp_auto_mute.sv ====
// Per-channel volume ramping and silence mute for a stereo sample stream
`timescale 1ns/1ps
`include "volume_ramp_map.svh"
module volume_ramp_auto_mute
   import volume_ramp_pkg::*;
#(
   parameter logic [8*RUN_W-1:0] SILENCE_CNTS = {
      RUN_W'(`SILENCE_CNT(`SILENCE_T7_US)), RUN_W'(`SILENCE_CNT(`SILENCE_T6_US)),
      RUN_W'(`SILENCE_CNT(`SILENCE_T5_US)), RUN_W'(`SILENCE_CNT(`SILENCE_T4_US)),
      RUN_W'(`SILENCE_CNT(`SILENCE_T3_US)), RUN_W'(`SILENCE_CNT(`SILENCE_T2_US)),
      RUN_W'(`SILENCE_CNT(`SILENCE_T1_US)), RUN_W'(`SILENCE_CNT(`SILENCE_T0_US))}
)(
   input  wire logic       sys_clk_i,
   input  wire logic       srst_i,
   // Register port
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic [7:0]      reg_rdata_o,
   // Level targets and emergency condition
   input  wire level_t     volume_target_left_i,
   input  wire level_t     volume_target_right_i,
   input  wire logic       emergency_i,
   // Sample input, one accepted frame per sample period
   input  wire logic       sample_valid_i,
   output logic            sample_ready_o,
   input  wire sample_t    sample_left_i,
   input  wire sample_t    sample_right_i,
   // Frame output with the applied levels
   output logic            frame_valid_o,
   input  wire logic       frame_ready_i,
   output frame_t          frame_o,
   output level_t          level_left_o,
   output level_t          level_right_o,
   output logic [1:0]      silence_muted_o
);
   // ******************************
   // Helpers
   // ******************************
   // Step size in 0.5 dB codes: 4, 2, 1, 0.5 dB
   function automatic level_t step_codes(input logic [1:0] code);
      step_codes = 8'h08 >> code;
   endfunction

   function automatic logic [1:0] rate_limit(input logic [1:0] code);
      rate_limit = 2'((3'h1 << code) - 3'h1);
   endfunction

   // Moves by one step, clamped so the target is never passed
   function automatic level_t step_toward(input level_t cur, input level_t tgt,
                                          input level_t stp);
      if (cur < tgt) begin
         step_toward = (tgt - cur < stp) ? tgt : level_t'(cur + stp);
      end else begin
         step_toward = (cur - tgt < stp) ? tgt : level_t'(cur - stp);
      end
   endfunction

   function automatic run_t silence_limit(input logic [2:0] code);
      silence_limit = SILENCE_CNTS[code*RUN_W +: RUN_W];
   endfunction

   // ******************************
   // Registers
   // ******************************
   logic [7:0] normal_q, normal_d, emerg_q, emerg_d;
   logic [7:0] sctrl_q, sctrl_d, sdelay_q, sdelay_d;
   logic [7:0] rdata_q, rdata_d;

   always_comb begin
      normal_d = normal_q;
      emerg_d  = emerg_q;
      sctrl_d  = sctrl_q;
      sdelay_d = sdelay_q;
      rdata_d  = rdata_q;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `NORMAL_RAMP_OFS:    normal_d = reg_wdata_i;
            `EMERGENCY_RAMP_OFS: emerg_d  = reg_wdata_i;
            `SILENCE_CTRL_OFS:   sctrl_d  = reg_wdata_i;
            `SILENCE_DELAY_OFS:  sdelay_d = reg_wdata_i;
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `NORMAL_RAMP_OFS:    rdata_d = normal_q;
            `EMERGENCY_RAMP_OFS: rdata_d = emerg_q;
            `SILENCE_CTRL_OFS:   rdata_d = sctrl_q;
            `SILENCE_DELAY_OFS:  rdata_d = sdelay_q;
            default:             rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         normal_q <= `NORMAL_RAMP_RST;
         emerg_q  <= `EMERGENCY_RAMP_RST;
         sctrl_q  <= `SILENCE_CTRL_RST;
         sdelay_q <= `SILENCE_DELAY_RST;
         rdata_q  <= 8'h00;
      end else begin
         normal_q <= normal_d;
         emerg_q  <= emerg_d;
         sctrl_q  <= sctrl_d;
         sdelay_q <= sdelay_d;
         rdata_q  <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // ******************************
   // Silence detection
   // ******************************
   run_t       run_q [2], run_d [2];
   logic [1:0] qualify, enable, mute_q, mute_d;
   logic       accept;
   logic       ready_q;

   frame_stream_if fifo_s ();

   // Count a frame only when it is really offered as taken, never in the cycle after reset
   assign accept = sample_valid_i & fifo_s.ready & ready_q;

   always_comb begin
      sample_t smp;
      logic [2:0] dcode;
      smp   = '0;
      dcode = '0;
      enable[1] = sctrl_q[`ENABLE_RIGHT_POS];
      enable[0] = sctrl_q[`ENABLE_LEFT_POS];
      for (int c = 0; c < 2; c++) begin
         smp   = (c == 0) ? sample_left_i : sample_right_i;
         dcode = (c == 0) ? sdelay_q[`DELAY_LEFT_POS +: 3] : sdelay_q[`DELAY_RIGHT_POS +: 3];
         qualify[c] = (run_q[c] >= silence_limit(dcode));
         run_d[c]   = run_q[c];
         if (accept) begin
            if (smp != '0) begin
               run_d[c] = '0;
            end else if (!qualify[c]) begin
               run_d[c] = run_t'(run_q[c] + 1'b1);
            end
         end
         qualify[c] = qualify[c] & enable[c];
      end
      if (sctrl_q[`GROUPING_POS]) begin
         mute_d = {2{&qualify}};
      end else begin
         mute_d = qualify;
      end
   end

   // ******************************
   // Level ramps
   // ******************************
   level_t      level_q [2], level_d [2];
   logic [1:0]  tick_q [2], tick_d [2];
   ramp_state_t state_q [2], state_d [2];

   always_comb begin
      level_t     goal;
      logic [1:0] rate, stp;
      goal = '0;
      rate = '0;
      stp  = '0;
      for (int c = 0; c < 2; c++) begin
         level_d[c] = level_q[c];
         tick_d[c]  = tick_q[c];
         goal = (c == 0) ? volume_target_left_i : volume_target_right_i;
         if (emergency_i || mute_q[c]) begin
            goal = `LEVEL_MUTE;
         end
         if (level_q[c] == goal) begin
            state_d[c] = RAMP_IDLE;
         end else if (emergency_i) begin
            state_d[c] = RAMP_EMERGENCY;
         end else if (goal > level_q[c]) begin
            state_d[c] = RAMP_DOWN;
         end else begin
            state_d[c] = RAMP_UP;
         end
         unique case (state_d[c])
            RAMP_EMERGENCY: begin
               rate = emerg_q[`DOWN_RATE_POS +: 2];
               stp  = emerg_q[`DOWN_STEP_POS +: 2];
            end
            RAMP_DOWN: begin
               rate = normal_q[`DOWN_RATE_POS +: 2];
               stp  = normal_q[`DOWN_STEP_POS +: 2];
            end
            RAMP_UP, RAMP_IDLE: begin
               rate = normal_q[`UP_RATE_POS +: 2];
               stp  = normal_q[`UP_STEP_POS +: 2];
            end
         endcase
         if (state_d[c] == RAMP_IDLE) begin
            tick_d[c] = 2'b00;
         end else if (rate == `RATE_INSTANT) begin
            level_d[c] = goal;
            tick_d[c]  = 2'b00;
         end else if (accept) begin
            if (tick_q[c] >= rate_limit(rate)) begin
               level_d[c] = step_toward(level_q[c], goal, step_codes(stp));
               tick_d[c]  = 2'b00;
            end else begin
               tick_d[c] = tick_q[c] + 2'b01;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         for (int c = 0; c < 2; c++) begin
            run_q[c]   <= '0;
            level_q[c] <= `LEVEL_0DB;
            tick_q[c]  <= 2'b00;
            state_q[c] <= RAMP_IDLE;
         end
         mute_q <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            run_q[c]   <= run_d[c];
            level_q[c] <= level_d[c];
            tick_q[c]  <= tick_d[c];
            state_q[c] <= state_d[c];
         end
         mute_q <= mute_d;
      end
   end

   // ******************************
   // Output buffer
   // ******************************
   // The frame carries the level in force for that sample; a stall holds the input
   assign fifo_s.valid            = accept;
   assign fifo_s.data.left        = sample_left_i;
   assign fifo_s.data.right       = sample_right_i;
   assign fifo_s.data.level_left  = level_q[0];
   assign fifo_s.data.level_right = level_q[1];

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= 1'b1;
      end
   end

   // Buffer ready is itself a flop; gated so nothing is offered during reset
   assign sample_ready_o  = fifo_s.ready & ready_q;
   assign level_left_o    = level_q[0];
   assign level_right_o   = level_q[1];
   assign silence_muted_o = mute_q;

   frame_buffer u_frame_buffer (
      .sys_clk_i   (sys_clk_i),
      .srst_i      (srst_i),
      .in_s        (fifo_s),
      .out_valid_o (frame_valid_o),
      .out_ready_i (frame_ready_i),
      .out_data_o  (frame_o)
   );
endmodule

// ==== volume_ramp_chk.sv ====
// Port checker for the volume ramp and silence mute block
`timescale 1ns/1ps
`include "volume_ramp_map.svh"
module volume_ramp_chk
   import volume_ramp_pkg::*;
#(
   parameter logic [8*RUN_W-1:0] SILENCE_CNTS = '0
)(
   input wire logic       sys_clk_i,
   input wire logic       srst_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       emergency_i,
   input wire logic       sample_valid_i,
   input wire logic       sample_ready_o,
   input wire logic       frame_valid_o,
   input wire logic       frame_ready_i,
   input wire frame_t     frame_o,
   input wire level_t     level_left_o,
   input wire level_t     level_right_o,
   input wire logic [1:0] silence_muted_o
);
   // *****
   // Shadow of the ramp and mute settings
   // *****
   logic [7:0] nrm_d, nrm_q, emr_d, emr_q, ctl_d, ctl_q;
   logic       inst;
   logic       tk;
   always_comb begin
      nrm_d = nrm_q;
      emr_d = emr_q;
      ctl_d = ctl_q;
      if (reg_wr_i && reg_addr_i == `NORMAL_RAMP_OFS) nrm_d = reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `EMERGENCY_RAMP_OFS) emr_d = reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `SILENCE_CTRL_OFS) ctl_d = reg_wdata_i;
      if (srst_i) begin
         nrm_d = `NORMAL_RAMP_RST;
         emr_d = `EMERGENCY_RAMP_RST;
         ctl_d = `SILENCE_CTRL_RST;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      nrm_q <= nrm_d;
      emr_q <= emr_d;
      ctl_q <= ctl_d;
   end
   // Any instant code lets the level jump, so step checks stand aside then
   assign inst = nrm_q[7:6] == 2'b11 || nrm_q[3:2] == 2'b11 || emr_q[7:6] == 2'b11;
   assign tk   = sample_valid_i && sample_ready_o;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);

   a_unmapped_read: assert property (
      reg_rd_i && (reg_addr_i < 8'h4e || reg_addr_i > 8'h51) |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   a_frame_holds: assert property (
      frame_valid_o && !frame_ready_i |=> frame_valid_o && $stable(frame_o))
      else $error("frame changed before taken");
   a_step_bound: assert property (
      !inst && !$past(inst) |-> 8'(level_left_o - $past(level_left_o) + 8'h08) <= 8'h10
      && 8'(level_right_o - $past(level_right_o) + 8'h08) <= 8'h10)
      else $error("level moved more than one step");
   a_move_on_frame: assert property (
      $changed(level_left_o) && !inst && !$past(inst) |-> $past(tk) || $past(tk, 2))
      else $error("level moved without a sample");
   a_mute_enable: assert property (
      (silence_muted_o & ~(ctl_q[1:0] | $past(ctl_q[1:0]))) == 2'b00)
      else $error("mute on a disabled channel");
   a_group_pair: assert property (
      ctl_q[2] && $past(ctl_q[2]) |-> silence_muted_o != 2'b01 && silence_muted_o != 2'b10)
      else $error("grouped mute on one channel");
   a_mute_instant: assert property (
      silence_muted_o[0] && nrm_q[7:6] == 2'b11 && !emergency_i |=> level_left_o == 8'hff)
      else $error("silence mute did not jump");
   a_emerg_instant: assert property (
      emergency_i && emr_q[7:6] == 2'b11 |=> level_left_o == 8'hff && level_right_o == 8'hff)
      else $error("emergency mute did not jump");

   c_taken: cover property (tk);
   c_both_muted: cover property (silence_muted_o == 2'b11);
   c_full: cover property (frame_valid_o && !sample_ready_o);
endmodule

bind volume_ramp_auto_mute volume_ramp_chk #(.SILENCE_CNTS(SILENCE_CNTS)) u_chk (.*);

// ==== audio_src_model.sv ====
// Sample source standing in front of the ramp block
`timescale 1ns/1ps
module audio_src_model
   import volume_ramp_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic ready_i,
   output logic      valid_o,
   output sample_t   left_o,
   output sample_t   right_o
);
   int misses = 0;
   initial begin
      valid_o = 1'b0;
      left_o  = '0;
      right_o = '0;
   end
   // Frame held until taken or for at most 50 cycles; released lines carry the inverse so stale data never looks valid
   task automatic send(input sample_t l, input sample_t r);
      int i;
      @(posedge clk_i);
      valid_o <= 1'b1;
      left_o  <= l;
      right_o <= r;
      for (i = 0; i < 50; i++) begin
         @(negedge clk_i);
         if (ready_i === 1'b1) break;
      end
      if (i == 50) misses++;
      @(posedge clk_i);
      valid_o <= 1'b0;
      left_o  <= ~l;
      right_o <= ~r;
   endtask
endmodule

// ==== volume_ramp_auto_mute_tb.sv ====
// Self-checking bench for the volume ramp and silence mute block
`timescale 1ns/1ps
`include "volume_ramp_map.svh"
module volume_ramp_auto_mute_tb;
   import volume_ramp_pkg::*;
   logic       sys_clk_i, srst_i, reg_wr_i, reg_rd_i, emer, f_rdy;
   logic [7:0] addr, wdata, rdata;
   level_t     tgt_l, tgt_r, lvl_l, lvl_r;
   logic       s_valid, s_ready, f_valid;
   sample_t    s_l, s_r;
   frame_t     f_data;
   logic [1:0] mute;
   int         n_fail = 0;
   int         num_checks = 0;

   // Short silence limits 2..9 keep the zero runs brief
   volume_ramp_auto_mute #(.SILENCE_CNTS({19'h9, 19'h8, 19'h7, 19'h6,
      19'h5, 19'h4, 19'h3, 19'h2})) uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .volume_target_left_i(tgt_l), .volume_target_right_i(tgt_r),
      .emergency_i(emer), .sample_valid_i(s_valid), .sample_ready_o(s_ready),
      .sample_left_i(s_l), .sample_right_i(s_r), .frame_valid_o(f_valid),
      .frame_ready_i(f_rdy), .frame_o(f_data), .level_left_o(lvl_l),
      .level_right_o(lvl_r), .silence_muted_o(mute));
   audio_src_model src (.clk_i(sys_clk_i), .ready_i(s_ready), .valid_o(s_valid),
      .left_o(s_l), .right_o(s_r));

   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      addr     <= a;
      wdata    <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      addr     <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(rdata, exp);
   endtask
   task automatic send(input sample_t l, input sample_t r, input int n);
      repeat (n) src.send(l, r);
      cyc(3);
   endtask

   // *****
   // Scenarios
   // *****
   task automatic t_regs();
      logic [7:0] rst [4] = '{8'h33, 8'h30, 8'h07, 8'h00};
      for (int i = 0; i < 4; i++) begin
         rd(8'(8'h4e + i), rst[i]);
         wr(8'(8'h4e + i), 8'h5a);
         rd(8'(8'h4e + i), 8'h5a);
      end
      wr(8'h52, 8'hff);
      rd(8'h52, 8'h00);
   endtask
   // Preset the level with instant codes, then count frames to the first step
   task automatic ramp(input logic [7:0] ofs, cfg, input level_t from, to, input int per,
                       input int d);
      wr(`NORMAL_RAMP_OFS, 8'hff);
      tgt_l <= from;
      tgt_r <= from;
      cyc(3);
      chk({lvl_l, lvl_r}, {from, from});
      wr(ofs, cfg);
      tgt_l <= to;
      tgt_r <= to;
      emer  <= (ofs == `EMERGENCY_RAMP_OFS);
      send(24'h1, 24'h1, per - 1);
      chk(lvl_l, from);
      send(24'h1, 24'h1, 1);
      chk({lvl_l, lvl_r}, {2{8'(from + d)}});
      @(posedge sys_clk_i);
      emer <= 1'b0;
   endtask
   task automatic t_ramps();
      for (int r = 0; r < 3; r++) begin
         for (int s = 0; s < 4; s++) begin
            ramp(`NORMAL_RAMP_OFS, 8'(r * 64 + s * 16 + 15), 8'h40, 8'h60, 1 << r, 8 >> s);
            ramp(`NORMAL_RAMP_OFS, 8'(240 + r * 4 + s), 8'h60, 8'h40, 1 << r, -(8 >> s));
            ramp(`EMERGENCY_RAMP_OFS, 8'(r * 64 + s * 16), 8'h40, 8'h40, 1 << r, 8 >> s);
         end
      end
      ramp(`NORMAL_RAMP_OFS, 8'h0f, 8'h40, 8'h43, 1, 3);
      wr(`EMERGENCY_RAMP_OFS, 8'hc0);
      emer <= 1'b1;
      cyc(2);
      chk({lvl_l, lvl_r}, 16'hffff);
      @(posedge sys_clk_i);
      emer <= 1'b0;
   endtask
   task automatic t_silence();
      tgt_l <= 8'h30;
      tgt_r <= 8'h30;
      wr(`SILENCE_DELAY_OFS, 8'h07);
      wr(`SILENCE_CTRL_OFS, 8'h03);
      send(24'h1, 24'h1, 1);
      send(24'h0, 24'h1, 1);
      chk(mute, 2'b00);
      send(24'h0, 24'h1, 2);
      chk({mute, lvl_l}, {2'b01, 8'h38});
      send(24'h1, 24'h0, 8);
      chk({mute, lvl_l}, {2'b00, 8'h30});
      send(24'h1, 24'h0, 1);
      chk(mute, 2'b10);
      wr(`SILENCE_DELAY_OFS, 8'h00);
      wr(`SILENCE_CTRL_OFS, 8'h07);
      send(24'h0, 24'h1, 3);
      chk(mute, 2'b00);
      send(24'h0, 24'h0, 2);
      chk(mute, 2'b11);
      wr(`SILENCE_CTRL_OFS, 8'h02);
      cyc(3);
      chk(mute, 2'b10);
      wr(`SILENCE_CTRL_OFS, 8'h00);
      cyc(3);
      chk(mute, 2'b00);
   endtask
   task automatic t_buffer();
      send(24'h1, 24'h1, 1);
      @(posedge sys_clk_i);
      f_rdy <= 1'b0;
      src.send(24'h11, 24'h1);
      src.send(24'h22, 24'h1);
      cyc(2);
      chk({s_ready, f_valid, f_data[63:40]}, {2'b01, 24'h11});
      chk(f_data[15:0], {lvl_l, lvl_r});
      @(posedge sys_clk_i);
      f_rdy <= 1'b1;
      cyc(1);
      chk(f_data[63:40], 24'h22);
      cyc(1);
      chk(f_valid, 1'b0);
   endtask

   task automatic final_report();
      if (src.misses != 0) n_fail++;
      if (n_fail == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      srst_i   = 1'b1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      addr     = 8'h00;
      wdata    = 8'h00;
      tgt_l    = 8'h30;
      tgt_r    = 8'h30;
      emer     = 1'b0;
      f_rdy    = 1'b1;
      repeat (4) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      t_regs();
      t_ramps();
      t_silence();
      t_buffer();
      final_report();
   end
   initial begin
      repeat (40000) @(posedge sys_clk_i);
      n_fail++;
      final_report();
   end
endmodule
